// *** boot_strap_regs.vh ***
// Register offsets, field positions, flow, lane and state codes for the boot strap block
`ifndef BOOT_STRAP_REGS_VH
`define BOOT_STRAP_REGS_VH
`define OFS_STRAP_STATUS 12'h000
`define OFS_BOOT_CTRL 12'h004
`define OFS_FLASH_CFG 12'h008
`define BIT_FLOW 2:0
`define BIT_ADDR4 3
`define BIT_CAPAR 4
`define BIT_TWO 5
`define BIT_FOUR 6
`define BIT_REL 7
`define BIT_VALID 8
`define BIT_FLOW_BAD 9
`define BIT_LANE_BAD 10
`define BIT_GO 0
`define FLOW_QSPI 3'h0
`define LANES_1 2'h0
`define LANES_2 2'h1
`define LANES_4 2'h2
`define ST_IDLE 2'h0
`define ST_LOAD 2'h1
`define ST_RUN 2'h2
`define ST_HOLD 2'h3
`define SETTLE_LAST 2'h2
`endif

// *** strap_sync.v ***
// Two-flop synchroniser for one board level
module strap_sync (
   input wire pclk,
   input wire presetn,
   input wire d,
   output reg q
);
   reg meta;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // strap_sync

// *** flash_boot_strap_config.v ***
// Strap capture and boot flow sequencing for the boot processor
`include "boot_strap_regs.vh"
module flash_boot_strap_config (
   input wire pclk,
   input wire presetn,
   input wire [2:0] boot_flow_select,
   input wire flash_addr_width_strap,
   input wire cmd_addr_parallel_strap,
   input wire two_lane_strap,
   input wire four_lane_strap,
   input wire boot_cpu_release_strap,
   input wire load_done,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg flash_addr_4byte,
   output reg [1:0] flash_lanes,
   output reg cmd_addr_on_lanes,
   output reg load_start,
   output reg boot_cpu_reset_n
);
   wire [7:0] raw;
   wire [7:0] sync;
   reg [1:0] settle;
   reg captured;
   reg [7:0] strap;
   reg [1:0] state;
   reg [1:0] next_state;
   reg go_seen;
   wire flow_ok;
   wire lane_bad;
   wire [10:0] status;
   wire hit;
   assign raw = {boot_cpu_release_strap, four_lane_strap, two_lane_strap,
      cmd_addr_parallel_strap, flash_addr_width_strap, boot_flow_select};
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_sync
         strap_sync u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .d(raw[i]),
            .q(sync[i])
         );
      end
   endgenerate
   // Wait for the synchronisers to fill before the single capture
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle <= 2'h0;
         captured <= 1'b0;
         strap <= 8'h00;
      end else if (!captured) begin
         settle <= settle + 2'h1;
         if (settle == `SETTLE_LAST) begin
            captured <= 1'b1;
            strap <= sync;
         end
      end
   end
   assign flow_ok = (strap[`BIT_FLOW] == `FLOW_QSPI);
   // Both lanes high is illegal; quad wins so the port stays usable
   assign lane_bad = strap[`BIT_TWO] & strap[`BIT_FOUR];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_addr_4byte <= 1'b0;
         flash_lanes <= `LANES_1;
         cmd_addr_on_lanes <= 1'b0;
      end else begin
         flash_addr_4byte <= strap[`BIT_ADDR4];
         cmd_addr_on_lanes <= strap[`BIT_CAPAR];
         if (strap[`BIT_FOUR])
            flash_lanes <= `LANES_4;
         else if (strap[`BIT_TWO])
            flash_lanes <= `LANES_2;
         else
            flash_lanes <= `LANES_1;
      end
   end
   always @* begin
      next_state = state;
      case (state)
         `ST_IDLE: begin
            if (captured) begin
               if (strap[`BIT_REL] && flow_ok)
                  next_state = `ST_LOAD;
               else
                  next_state = `ST_HOLD;
            end
         end
         `ST_LOAD: begin
            if (load_done)
               next_state = `ST_RUN;
         end
         `ST_RUN: next_state = `ST_RUN;
         `ST_HOLD: begin
            // Software may rerun the flow after a held release; a reserved code stays in hold
            if (go_seen && flow_ok)
               next_state = `ST_LOAD;
         end
         default: next_state = `ST_IDLE;
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= `ST_IDLE;
         load_start <= 1'b0;
         boot_cpu_reset_n <= 1'b0;
      end else begin
         state <= next_state;
         load_start <= (state != `ST_LOAD) && (next_state == `ST_LOAD);
         boot_cpu_reset_n <= (next_state == `ST_RUN);
      end
   end
   assign status = {lane_bad, ~flow_ok & captured, captured, strap};
   assign hit = psel & ~penable;
   // Single wait-free APB slave; unmapped offsets answer with pslverr
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         go_seen <= 1'b0;
      end else begin
         pready <= hit;
         pslverr <= 1'b0;
         go_seen <= 1'b0;
         prdata <= 32'h00000000;
         if (hit) begin
            case (paddr)
               `OFS_STRAP_STATUS: prdata <= {21'h000000, status};
               `OFS_BOOT_CTRL: begin
                  prdata <= {30'h00000000, state};
                  if (pwrite)
                     go_seen <= pwdata[`BIT_GO];
               end
               `OFS_FLASH_CFG: prdata <= {28'h0000000, cmd_addr_on_lanes,
                  flash_lanes, flash_addr_4byte};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule // flash_boot_strap_config

// *** boot_sva.sv ***
// Checker on the strap block's ports
module boot_sva (input logic pclk, presetn, psel, penable, pready, load_start, load_done,
   input logic boot_cpu_reset_n, flash_addr_4byte, input logic [1:0] flash_lanes);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s; psel && !penable; endsequence
   lane_code_a: assert property (flash_lanes != 2'h3) else $error("lanes");
   start_pulse_a: assert property (load_start |=> !load_start) else $error("start");
   fetch_first_a: assert property (load_start |-> !boot_cpu_reset_n) else $error("early");
   cpu_run_a: assert property (load_done |-> ##[0:2] boot_cpu_reset_n) else $error("run");
   cpu_held_a: assert property (!$fell(boot_cpu_reset_n)) else $error("cpu");
   width_held_a: assert property (!$fell(flash_addr_4byte)) else $error("width");
   lanes_held_a: assert property ((|flash_lanes) |=> $stable(flash_lanes)) else $error("hold");
   apb_answer_a: assert property (setup_s |=> pready ##1 !pready) else $error("apb");
endmodule // boot_sva
bind flash_boot_strap_config boot_sva u_sva (.*);

// *** flash_model.sv ***
// Flash side: reports fetch done lat+2 cycles after it samples a start
module flash_model (input logic pclk, presetn, load_start, input logic [3:0] lat,
   output logic load_done);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] n;
   always @(posedge pclk or negedge presetn)
      if (!presetn) {load_done, n} <= 6'h0;
      else begin
         load_done <= n == 5'h1;
         n <= load_start ? {1'b0, lat} + 5'h2 : n - {4'h0, |n};
      end
endmodule // flash_model

// *** tb_top.sv ***
// Bench for strap capture and flash hand-off
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pready, pslverr, ls, ld, e;
   logic [7:0] s, cs;
   logic pwrite = 0;
   logic [31:0] pwdata = 0;
   logic [3:0] lat;
   logic [11:0] paddr = 0;
   logic [31:0] prdata, d, x;
   wire [4:0] o;
   int err_total = 0, n_compared = 0;
   flash_boot_strap_config dut (.pclk, .presetn, .boot_flow_select(s[2:0]),
      .flash_addr_width_strap(s[3]), .cmd_addr_parallel_strap(s[4]), .two_lane_strap(s[5]),
      .four_lane_strap(s[6]), .boot_cpu_release_strap(s[7]), .load_done(ld), .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .load_start(ls),
      .flash_addr_4byte(o[0]), .flash_lanes(o[2:1]), .cmd_addr_on_lanes(o[3]), .boot_cpu_reset_n(o[4]));
   flash_model fm (.pclk, .presetn, .load_start(ls), .lat, .load_done(ld));
   initial forever #20 pclk = ~pclk;
   initial begin
      #100000 err_total++;
      end_sim;
   end
   task end_sim;
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] g, w);
      n_compared++;
      if (g !== w) begin
         err_total++;
         $display("ERROR %0t got %h want %h", $time, g, w);
      end
   endtask
   task rd(input logic [11:0] a, input logic w = 0, input logic [31:0] wd = 0);
      psel <= 1;
      pwrite <= w;
      pwdata <= wd;
      paddr <= a;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      pwrite <= 0;
      @(posedge pclk);
   endtask
   initial begin
      void'($urandom(32'hBC28));
      for (int i = 0; i < 6; i++) begin
         presetn <= 0;
         s <= {i != 4, i % 3 == 2, i % 3 == 1, 2'($urandom), i == 5 ? 3'($urandom_range(7, 1)) : 3'h0};
         lat <= 4'($urandom);
         repeat (20) @(posedge pclk);
         chk({27'h0, o}, 32'h0);
         presetn <= 1;
         cs = s;
         x = {27'h0, s[7] && s[2:0] == 3'h0, s[4], s[6] ? 2'h2 : {1'b0, s[5]}, s[3]};
         repeat (8) @(posedge pclk);
         s <= s ^ 8'h9F;
         repeat (30) @(posedge pclk);
         chk({27'h0, o}, x);
         rd(12'h008);
         chk(d, {28'h0, x[3:0]});
         rd(12'hFF0);
         chk({31'h0, e}, 32'h1);
         rd(12'h000);
         chk(d, {21'h0, 1'b0, cs[2:0] != 3'h0, 1'b1, cs});
         rd(12'h004);
         chk(d, {30'h0, x[4] ? 2'h2 : 2'h3});
         rd(12'h004, 1'b1, 32'h1);
         repeat (30) @(posedge pclk);
         rd(12'h004);
         chk(d, {30'h0, cs[2:0] == 3'h0 ? 2'h2 : 2'h3});
         chk({31'h0, o[4]}, {31'h0, cs[2:0] == 3'h0});
         $display("test %0d done", i);
      end
      end_sim;
   end
endmodule // tb_top
